// file: common/cccr_pkg.sv
// Package with register map, field layouts and timing constants of the codec control block.
package cccr_pkg;
  localparam logic [7:0] ADDR_RX_SLOT_CHAN3 = 8'h1A;
  localparam logic [7:0] ADDR_FRAME_BIT_OFFSET = 8'h1B;
  localparam logic [7:0] ADDR_IO_IRQ_MASK_LOW = 8'h1C;
  localparam logic [7:0] ADDR_IO_IRQ_MASK_HIGH = 8'h1D;
  localparam logic [7:0] ADDR_CHANNEL_IRQ_MASK = 8'h1E;
  localparam logic [7:0] ADDR_PERSIST_TIME_A = 8'h1F;
  localparam logic [7:0] ADDR_PERSIST_TIME_B = 8'h20;
  localparam logic [7:0] ADDR_IRQ_SOURCE = 8'h21;
  localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h22;
  localparam logic [7:0] ADDR_FAULT_IRQ_MASK = 8'h23;
  localparam logic [7:0] ADDR_LOOPBACK_SELECT = 8'h24;
  localparam logic [7:0] ADDR_TX_PREAMP_GAIN = 8'h25;
  localparam logic [7:0] ADDR_RX_AMP_GAIN_CH01 = 8'h26;
  localparam logic [7:0] ADDR_RX_AMP_GAIN_CH23 = 8'h27;
  localparam logic [7:0] ADDR_SILICON_REVISION = 8'h31;
  localparam logic [7:0] RST_RX_SLOT_CHAN3 = 8'h00;
  localparam logic [7:0] RST_FRAME_BIT_OFFSET = 8'h00;
  localparam logic [7:0] RST_IO_IRQ_MASK_LOW = 8'hFF;
  localparam logic [3:0] RST_IO_IRQ_MASK_HIGH = 4'hF;
  localparam logic [3:0] RST_CHANNEL_IRQ_MASK = 4'hF;
  localparam logic [7:0] RST_PERSIST = 8'h00;
  localparam logic [1:0] RST_FAULT_IRQ_MASK = 2'h3;
  localparam logic [7:0] RST_LOOPBACK = 8'h00;
  localparam logic [3:0] RST_TX_PREAMP = 4'h0;
  localparam logic [5:0] RST_RX_AMP = 6'h00;
  // Revision code value is arbitrary.
  localparam logic [3:0] SILICON_REV_CODE = 4'h5;
  localparam int SLOT_EN_BIT = 7;
  localparam int TX_OFS_LSB = 4;
  localparam int CLOCK_FAULT_IRQ_FLAG_BIT = 4;
  localparam int CLK_MHZ = 25;
  localparam int SAMPLE_US = 32;
  localparam int SAMPLE_CYCLES = SAMPLE_US * CLK_MHZ;
  localparam int PERSIST_UNIT_US = 64;
  localparam int PERSIST_TICKS = PERSIST_UNIT_US / SAMPLE_US;
  localparam logic [7:0] LIN_DATA_W = 8'h10;
  localparam logic [7:0] PCM_DATA_W = 8'h08;
  typedef enum logic [1:0] {CCCR_IDLE = 2'b00, CCCR_WAIT = 2'b01, CCCR_RUN = 2'b10} cccr_frame_t;
endpackage

// file: rtl/cccr_fifo.sv
// Parameterised valid/ready FIFO in the receive sample path.
`timescale 1ns/1ps
module cccr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] count;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready && clk_en;
  assign pop = out_valid && out_ready && clk_en;
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// file: rtl/cccr_top.sv
// Control registers, frame timing, input persistency filtering and interrupt sources of the codec.
// How it works
// - Enabled channel 3 slot captured to output.
// - Linear mode takes two consecutive slots.
// - Transmit frame starts offset bit clocks late.
// - Receive frame starts offset bit clocks late.
// - I/O mask bit one blocks line interrupt.
// - Output-configured lines never request interrupts.
// - Filtered inputs interrupt after stable persistency.
// - Channel mask disables channel or CS lines.
// - A/B inputs multiplexed or fixed by mode.
// - Persistency width is register times 64us.
// - Zero persistency means every transition interrupts.
// - Inputs sampled every 32 microseconds.
// - Clock fault change sets source bit four.
// - Dynamic source bits cleared by read/mask.
// - Static mode uses source bits zero, two.
// - Alarm bits for clock count, reset.
// - Alarm read clears only inactive conditions.
// - Alarm mask blocks clock fault interrupt.
// - Digital loopback routes rx slot to tx.
// - Analog loopback feeds rx output back.
// - Preamp gain bit selects 0 or 3.52dB.
// - Three-bit receive gain code per channel.
`timescale 1ns/1ps
module cccr_top
  import cccr_pkg::*;
#(
  parameter int SAMPLE_DIV = SAMPLE_CYCLES,
  parameter logic [7:0] FRAME_BITS = 8'hFF
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic fixed_io_select,
  input wire logic linear_mode,
  input wire logic [11:0] io_dir_out,
  input wire logic [11:0] io_in,
  input wire logic [3:0] cs_in,
  input wire logic io_reg_read,
  input wire logic [3:0] io_reg_read_chan,
  input wire logic cs_reg_read,
  input wire logic por_event,
  input wire logic bit_clk,
  input wire logic frame_sync,
  input wire logic pcm_rx_line,
  output logic rx_sample_valid,
  input wire logic rx_sample_ready,
  output logic [15:0] rx_sample_data,
  output logic tx_frame_start,
  output logic rx_frame_start,
  output logic [3:0] digital_loop_sel,
  output logic [3:0] codec_side_loop_sel,
  output logic [3:0] tx_preamp_bits,
  output logic [11:0] rx_amp_code,
  output logic [7:0] tx_loop_slot,
  output logic irq
);
  logic [7:0] rx_slot_chan3;
  logic [7:0] frame_bit_offset;
  logic [11:0] io_irq_mask;
  logic [3:0] channel_irq_mask;
  logic [7:0] persist_time_a;
  logic [7:0] persist_time_b;
  logic [3:0] irq_source_bits;
  logic clock_fault_irq_flag;
  logic [1:0] fault_flags;
  logic [1:0] fault_irq_mask;
  logic [2:0] bclk_s;
  logic [2:0] fs_s;
  logic [2:0] dr_s;
  logic [11:0] io_s1, io_s2, io_s3;
  logic [3:0] cs_s1, cs_s2, cs_s3;
  logic bclk_q, fs_q, bclk_rise, fs_rise;
  // Only the agreeing pair of the last two stages is trusted as a level.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bclk_s <= '0;
      fs_s <= '0;
      dr_s <= '0;
      io_s1 <= '0;
      io_s2 <= '0;
      io_s3 <= '0;
      cs_s1 <= '0;
      cs_s2 <= '0;
      cs_s3 <= '0;
      bclk_q <= 1'b0;
      fs_q <= 1'b0;
    end
    else if (clk_en)
    begin
      bclk_s <= {bclk_s[1:0], bit_clk};
      fs_s <= {fs_s[1:0], frame_sync};
      dr_s <= {dr_s[1:0], pcm_rx_line};
      io_s1 <= io_in;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
      cs_s1 <= cs_in;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      if (bclk_s[1] == bclk_s[2])
      begin
        bclk_q <= bclk_s[2];
      end
      if (fs_s[1] == fs_s[2])
      begin
        fs_q <= fs_s[2];
      end
    end
  end
  assign bclk_rise = (bclk_s[1] == bclk_s[2]) && bclk_s[2] && !bclk_q;
  assign fs_rise = bclk_rise && fs_q;
  // Frame timing: offsets count bit clocks after the frame sync edge.
  cccr_frame_t frame_state;
  logic [2:0] ofs_cnt;
  logic [10:0] rx_bit_cnt;
  logic [7:0] bits_in_frame;
  logic frame_seen;
  logic clk_fault_now;
  logic [15:0] shift;
  logic dr_prev;
  logic [3:0] byte_bits;
  logic [1:0] need_bytes;
  logic fifo_in_valid, fifo_in_ready;
  logic [15:0] fifo_in_data;
  logic [6:0] cur_slot;
  assign cur_slot = rx_bit_cnt[9:3];
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame_state <= CCCR_IDLE;
      ofs_cnt <= '0;
      tx_frame_start <= 1'b0;
      rx_frame_start <= 1'b0;
      rx_bit_cnt <= '0;
      bits_in_frame <= '0;
      frame_seen <= 1'b0;
      clk_fault_now <= 1'b0;
    end
    else if (clk_en)
    begin
      tx_frame_start <= 1'b0;
      rx_frame_start <= 1'b0;
      if (fs_rise && !fs_s[2] == 1'b0 && frame_state != CCCR_WAIT)
      begin
        if (frame_seen)
        begin
          clk_fault_now <= (bits_in_frame != FRAME_BITS);
        end
        frame_seen <= 1'b1;
        bits_in_frame <= '0;
        ofs_cnt <= '0;
        frame_state <= CCCR_WAIT;
        tx_frame_start <= (frame_bit_offset[TX_OFS_LSB +: 3] == 3'h0);
        rx_frame_start <= (frame_bit_offset[2:0] == 3'h0);
        if (frame_bit_offset[2:0] == 3'h0)
        begin
          rx_bit_cnt <= '0;
        end
      end
      else if (bclk_rise)
      begin
        bits_in_frame <= bits_in_frame + 1'b1;
        rx_bit_cnt <= rx_bit_cnt + 1'b1;
        if (frame_state == CCCR_WAIT)
        begin
          ofs_cnt <= ofs_cnt + 1'b1;
          // A zero offset starts on the frame sync edge itself, so the wrapping count must not match it again.
          if (frame_bit_offset[TX_OFS_LSB +: 3] != 3'h0 && ofs_cnt + 3'h1 == frame_bit_offset[TX_OFS_LSB +: 3])
          begin
            tx_frame_start <= 1'b1;
          end
          if (frame_bit_offset[2:0] != 3'h0 && ofs_cnt + 3'h1 == frame_bit_offset[2:0])
          begin
            rx_frame_start <= 1'b1;
            rx_bit_cnt <= '0;
          end
          if (ofs_cnt == 3'h7)
          begin
            frame_state <= CCCR_RUN;
          end
        end
        if (frame_state == CCCR_RUN && !fs_q)
        begin
          frame_state <= CCCR_IDLE;
        end
      end
    end
  end
  // Channel 3 receive slot capture; linear mode spans the next slot too.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift <= '0;
      dr_prev <= 1'b0;
      byte_bits <= '0;
      need_bytes <= '0;
      fifo_in_valid <= 1'b0;
      fifo_in_data <= '0;
    end
    else if (clk_en)
    begin
      if (fifo_in_valid && fifo_in_ready)
      begin
        fifo_in_valid <= 1'b0;
      end
      // The slot count is reloaded on the frame start edge, so it trails the data by one bit clock.
      if (bclk_rise)
      begin
        dr_prev <= dr_s[2];
      end
      if (bclk_rise && rx_slot_chan3[SLOT_EN_BIT])
      begin
        if (rx_bit_cnt[2:0] == 3'h0 && cur_slot == rx_slot_chan3[6:0])
        begin
          need_bytes <= linear_mode ? 2'h2 : 2'h1;
          shift <= {15'h0000, dr_prev};
          byte_bits <= 4'h1;
        end
        else if (need_bytes != 2'h0)
        begin
          shift <= {shift[14:0], dr_prev};
          byte_bits <= byte_bits + 1'b1;
          if (byte_bits == PCM_DATA_W[3:0] - 4'h1 && need_bytes == 2'h1 && !linear_mode)
          begin
            need_bytes <= '0;
            fifo_in_valid <= 1'b1;
            fifo_in_data <= {8'h00, shift[6:0], dr_prev};
          end
          else if (byte_bits == 4'hF)
          begin
            need_bytes <= '0;
            fifo_in_valid <= 1'b1;
            fifo_in_data <= {shift[14:0], dr_prev};
          end
        end
      end
    end
  end
  assign tx_loop_slot = rx_slot_chan3;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  cccr_fifo #(.WIDTH(16), .DEPTH(16)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(rx_sample_ready && !rx_sample_valid),
    .out_data(fifo_out_data)
  );
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_sample_valid <= 1'b0;
      rx_sample_data <= '0;
    end
    else if (clk_en)
    begin
      if (rx_sample_valid)
      begin
        rx_sample_valid <= 1'b0;
      end
      else if (fifo_out_valid && rx_sample_ready)
      begin
        rx_sample_valid <= 1'b1;
        rx_sample_data <= fifo_out_data;
      end
    end
  end
  // Input sampling tick and persistency filters for A and B of each channel.
  logic [15:0] tick_cnt;
  logic tick;
  logic [3:0] in_a, in_b;
  logic [3:0] chg_a, chg_b;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end
    else if (clk_en)
    begin
      tick <= (tick_cnt == 16'(SAMPLE_DIV - 1));
      tick_cnt <= (tick_cnt == 16'(SAMPLE_DIV - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end
  // Multiplexed mode takes the channel pairs from the first two I/O lines.
  always_comb
  begin
    if (fixed_io_select)
    begin
      in_a = {io_s3[10], io_s3[6], io_s3[4], io_s3[0]};
      in_b = {io_s3[11], io_s3[7], io_s3[5], io_s3[1]};
    end
    else
    begin
      in_a = {4{io_s3[0]}};
      in_b = {4{io_s3[1]}};
    end
  end
  logic [3:0] stab_a, stab_b;
  logic [8:0] cnt_a [4];
  logic [8:0] cnt_b [4];
  logic [11:0] io_prev;
  logic [3:0] cs_prev;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stab_a <= '0;
      stab_b <= '0;
      chg_a <= '0;
      chg_b <= '0;
      io_prev <= '0;
      cs_prev <= '0;
      for (int i = 0; i < 4; i++)
      begin
        cnt_a[i] <= '0;
        cnt_b[i] <= '0;
      end
    end
    else if (clk_en)
    begin
      chg_a <= '0;
      chg_b <= '0;
      if (tick)
      begin
        io_prev <= io_s3;
        cs_prev <= cs_s3;
        for (int i = 0; i < 4; i++)
        begin
          if (in_a[i] == stab_a[i] || persist_time_a == 8'h00)
          begin
            cnt_a[i] <= '0;
            chg_a[i] <= (in_a[i] != stab_a[i]);
            stab_a[i] <= in_a[i];
          end
          else if (cnt_a[i] >= 9'({persist_time_a, 1'b0}) * 9'(PERSIST_TICKS / 2))
          begin
            cnt_a[i] <= '0;
            chg_a[i] <= 1'b1;
            stab_a[i] <= in_a[i];
          end
          else
          begin
            cnt_a[i] <= cnt_a[i] + 1'b1;
          end
          if (in_b[i] == stab_b[i] || persist_time_b == 8'h00)
          begin
            cnt_b[i] <= '0;
            chg_b[i] <= (in_b[i] != stab_b[i]);
            stab_b[i] <= in_b[i];
          end
          else if (cnt_b[i] >= 9'({persist_time_b, 1'b0}) * 9'(PERSIST_TICKS / 2))
          begin
            cnt_b[i] <= '0;
            chg_b[i] <= 1'b1;
            stab_b[i] <= in_b[i];
          end
          else
          begin
            cnt_b[i] <= cnt_b[i] + 1'b1;
          end
        end
      end
    end
  end
  // Line change requests: unfiltered lines request at once in static mode only, filtered ones via A/B.
  logic [11:0] io_raw_chg, io_req;
  logic [3:0] cs_req, chan_req;
  logic [11:0] filt_line;
  assign filt_line = fixed_io_select ? 12'hCF3 : 12'h003;
  always_comb
  begin
    io_raw_chg = tick ? (io_s3 ^ io_prev) & ~filt_line : 12'h000;
    io_req = io_raw_chg & ~io_irq_mask & ~io_dir_out;
    if (fixed_io_select)
    begin
      io_req = io_req | ({chg_b[3], chg_a[3], 2'b00, chg_b[2], chg_a[2], chg_b[1], chg_a[1], 2'b00,
                          chg_b[0], chg_a[0]} & ~io_irq_mask & ~io_dir_out);
      cs_req = (tick ? (cs_s3 ^ cs_prev) : 4'h0) & ~channel_irq_mask;
      chan_req = '0;
    end
    else
    begin
      cs_req = '0;
      chan_req = (chg_a & {4{~io_irq_mask[0] & ~io_dir_out[0]}}) | (chg_b & {4{~io_irq_mask[1] & ~io_dir_out[1]}});
      chan_req = chan_req & ~channel_irq_mask;
    end
  end
  // Source latches: a set in the same cycle as a clear wins.
  logic mask_write;
  logic [3:0] next_src;
  assign mask_write = reg_wr && reg_addr == ADDR_CHANNEL_IRQ_MASK;
  always_comb
  begin
    next_src = irq_source_bits;
    if (fixed_io_select)
    begin
      if (io_reg_read)
      begin
        next_src[0] = 1'b0;
      end
      if (cs_reg_read)
      begin
        next_src[2] = 1'b0;
      end
      next_src[1] = 1'b0;
      next_src[3] = 1'b0;
      next_src[0] = next_src[0] | (|io_req);
      next_src[2] = next_src[2] | (|cs_req);
    end
    else
    begin
      if (io_reg_read)
      begin
        next_src = next_src & ~io_reg_read_chan;
      end
      if (mask_write)
      begin
        next_src = next_src & ~reg_wdata[3:0];
      end
      next_src = next_src | chan_req;
    end
  end
  logic fault_rd, ckf_prev;
  assign fault_rd = reg_rd && reg_addr == ADDR_FAULT_FLAGS;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_source_bits <= '0;
      clock_fault_irq_flag <= 1'b0;
      fault_flags <= '0;
      ckf_prev <= 1'b0;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_source_bits <= next_src;
      ckf_prev <= fault_flags[0];
      if (fault_rd)
      begin
        fault_flags <= {por_event, clk_fault_now};
      end
      else
      begin
        fault_flags <= fault_flags | {por_event, clk_fault_now};
      end
      if (fault_flags[0] != ckf_prev && !fault_irq_mask[0])
      begin
        clock_fault_irq_flag <= 1'b1;
      end
      else if (reg_rd && reg_addr == ADDR_IRQ_SOURCE)
      begin
        clock_fault_irq_flag <= 1'b0;
      end
      irq <= (|next_src) || clock_fault_irq_flag;
    end
  end
  // Software-written registers.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_slot_chan3 <= RST_RX_SLOT_CHAN3;
      frame_bit_offset <= RST_FRAME_BIT_OFFSET;
      io_irq_mask <= {RST_IO_IRQ_MASK_HIGH, RST_IO_IRQ_MASK_LOW};
      channel_irq_mask <= RST_CHANNEL_IRQ_MASK;
      persist_time_a <= RST_PERSIST;
      persist_time_b <= RST_PERSIST;
      fault_irq_mask <= RST_FAULT_IRQ_MASK;
      digital_loop_sel <= RST_LOOPBACK[7:4];
      codec_side_loop_sel <= RST_LOOPBACK[3:0];
      tx_preamp_bits <= RST_TX_PREAMP;
      rx_amp_code <= {RST_RX_AMP, RST_RX_AMP};
    end
    else if (clk_en && reg_wr)
    begin
      if (reg_addr == ADDR_RX_SLOT_CHAN3)
        rx_slot_chan3 <= reg_wdata;
      else if (reg_addr == ADDR_FRAME_BIT_OFFSET)
        frame_bit_offset <= reg_wdata & 8'h77;
      else if (reg_addr == ADDR_IO_IRQ_MASK_LOW)
        io_irq_mask[7:0] <= reg_wdata;
      else if (reg_addr == ADDR_IO_IRQ_MASK_HIGH)
        io_irq_mask[11:8] <= reg_wdata[3:0];
      else if (reg_addr == ADDR_CHANNEL_IRQ_MASK)
        channel_irq_mask <= reg_wdata[3:0];
      else if (reg_addr == ADDR_PERSIST_TIME_A)
        persist_time_a <= reg_wdata;
      else if (reg_addr == ADDR_PERSIST_TIME_B)
        persist_time_b <= reg_wdata;
      else if (reg_addr == ADDR_FAULT_IRQ_MASK)
        fault_irq_mask <= reg_wdata[1:0];
      else if (reg_addr == ADDR_LOOPBACK_SELECT)
      begin
        digital_loop_sel <= reg_wdata[7:4];
        codec_side_loop_sel <= reg_wdata[3:0];
      end
      else if (reg_addr == ADDR_TX_PREAMP_GAIN)
        tx_preamp_bits <= reg_wdata[3:0];
      else if (reg_addr == ADDR_RX_AMP_GAIN_CH01)
        rx_amp_code[5:0] <= reg_wdata[5:0];
      else if (reg_addr == ADDR_RX_AMP_GAIN_CH23)
        rx_amp_code[11:6] <= reg_wdata[5:0];
    end
  end
  // Read data is registered so the port comes straight from a flip-flop.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata <= '0;
    end
    else if (clk_en && reg_rd)
    begin
      if (reg_addr == ADDR_RX_SLOT_CHAN3)
        reg_rdata <= rx_slot_chan3;
      else if (reg_addr == ADDR_FRAME_BIT_OFFSET)
        reg_rdata <= frame_bit_offset;
      else if (reg_addr == ADDR_IO_IRQ_MASK_LOW)
        reg_rdata <= io_irq_mask[7:0];
      else if (reg_addr == ADDR_IO_IRQ_MASK_HIGH)
        reg_rdata <= {4'h0, io_irq_mask[11:8]};
      else if (reg_addr == ADDR_CHANNEL_IRQ_MASK)
        reg_rdata <= {4'h0, channel_irq_mask};
      else if (reg_addr == ADDR_PERSIST_TIME_A)
        reg_rdata <= persist_time_a;
      else if (reg_addr == ADDR_PERSIST_TIME_B)
        reg_rdata <= persist_time_b;
      else if (reg_addr == ADDR_IRQ_SOURCE)
        reg_rdata <= {3'h0, clock_fault_irq_flag, irq_source_bits};
      else if (reg_addr == ADDR_FAULT_FLAGS)
        reg_rdata <= {6'h00, fault_flags};
      else if (reg_addr == ADDR_FAULT_IRQ_MASK)
        reg_rdata <= {6'h00, fault_irq_mask};
      else if (reg_addr == ADDR_LOOPBACK_SELECT)
        reg_rdata <= {digital_loop_sel, codec_side_loop_sel};
      else if (reg_addr == ADDR_TX_PREAMP_GAIN)
        reg_rdata <= {4'h0, tx_preamp_bits};
      else if (reg_addr == ADDR_RX_AMP_GAIN_CH01)
        reg_rdata <= {2'h0, rx_amp_code[5:0]};
      else if (reg_addr == ADDR_RX_AMP_GAIN_CH23)
        reg_rdata <= {2'h0, rx_amp_code[11:6]};
      else if (reg_addr == ADDR_SILICON_REVISION)
        reg_rdata <= {4'h0, SILICON_REV_CODE};
      else
        reg_rdata <= 8'h00;
    end
  end
endmodule

// file: tb/cccr_top_props.sv
// Port assertions for the codec control block.
`timescale 1ns/1ps
module cccr_top_props
  import cccr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic rx_sample_valid,
  input wire logic tx_frame_start,
  input wire logic rx_frame_start,
  input wire logic [3:0] digital_loop_sel,
  input wire logic [3:0] codec_side_loop_sel,
  input wire logic [3:0] tx_preamp_bits,
  input wire logic [11:0] rx_amp_code,
  input wire logic [7:0] tx_loop_slot,
  input wire logic irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic wr;
  assign wr = reg_wr && clk_en;
  slot_copy_a:
    assert property (wr && reg_addr == ADDR_RX_SLOT_CHAN3 |=> tx_loop_slot == $past(reg_wdata)) else $error("slot");
  dig_loop_a:
    assert property (wr && reg_addr == ADDR_LOOPBACK_SELECT |=> digital_loop_sel == $past(reg_wdata[7:4]))
    else $error("dloop");
  ana_loop_a:
    assert property (wr && reg_addr == ADDR_LOOPBACK_SELECT |=> codec_side_loop_sel == $past(reg_wdata[3:0]))
    else $error("aloop");
  preamp_gain_a:
    assert property (wr && reg_addr == ADDR_TX_PREAMP_GAIN |=> tx_preamp_bits == $past(reg_wdata[3:0]))
    else $error("preamp");
  rx_gain_a:
    assert property (wr && reg_addr == ADDR_RX_AMP_GAIN_CH01 |=> rx_amp_code[5:0] == $past(reg_wdata[5:0]))
    else $error("rx gain");
  sample_pulse_a:
    assert property (rx_sample_valid |=> !rx_sample_valid) else $error("valid pulse");
  tx_start_a:
    assert property (tx_frame_start |=> !tx_frame_start) else $error("tx start");
  rx_start_a:
    assert property (rx_frame_start |=> !rx_frame_start) else $error("rx start");
  cover property (rx_sample_valid);
  cover property ($rose(irq));
  cover property (tx_frame_start);
endmodule
bind cccr_top cccr_top_props props (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rx_sample_valid(rx_sample_valid), .irq(irq),
  .tx_frame_start(tx_frame_start), .rx_frame_start(rx_frame_start), .digital_loop_sel(digital_loop_sel),
  .codec_side_loop_sel(codec_side_loop_sel), .tx_preamp_bits(tx_preamp_bits), .rx_amp_code(rx_amp_code),
  .tx_loop_slot(tx_loop_slot));

// file: tb/cccr_pcm_source.sv
// PCM highway source: free-running bit clock, frame sync and receive data.
`timescale 1ns/1ps
module cccr_pcm_source #(
  parameter int NBITS = 32
) (
  output logic bit_clk,
  output logic frame_sync,
  output logic pcm_rx_line
);
  int b;
  logic [7:0] v;
  initial
  begin
    b = 0;
    bit_clk = 1'b0;
    frame_sync = 1'b0;
    pcm_rx_line = 1'b1;
  end
  // Data moves on the falling edge so it is stable at every rising edge.
  always
  begin
    #160 bit_clk = 1'b1;
    #160 bit_clk = 1'b0;
    b = (b + 1) % NBITS;
    frame_sync = (b == 0);
    v = 8'hC0 | 8'(b / 8);
    pcm_rx_line = v[7 - b % 8];
  end
endmodule

// file: tb/cccr_top_bench.sv
// Self-checking bench for the codec control block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module cccr_top_bench;
  import cccr_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic fsel = 1'b0;
  logic por = 1'b0;
  logic iord = 1'b0;
  logic lin = 1'b0;
  logic rdy = 1'b1;
  logic [11:0] dir = 12'h000;
  logic [11:0] io = 12'h000;
  logic [7:0] reg_rdata, slot;
  logic [15:0] rx_data;
  logic [3:0] dls, cls, tx_preamp_gain;
  logic [11:0] rx_amp_gain;
  logic rx_valid, irq, bclk, fsync, rxd, rfs, tfs;
  int bad_count = 0;
  int n_tests = 0;
  int nf = 0;
  localparam logic [7:0] WA [9] = '{8'h1A, 8'h1B, 8'h1F, 8'h20, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27};
  localparam logic [7:0] WD [9] = '{8'h81, 8'h53, 8'h02, 8'h00, 8'h01, 8'h5A, 8'h0B, 8'h2C, 8'h15};
  localparam logic [7:0] WM [9] = '{8'hFF, 8'h77, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'h0F, 8'h3F, 8'h3F};
  localparam logic [7:0] RV [14] = '{8'h00, 8'h00, 8'hFF, 8'h0F, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03,
    8'h00, 8'h00, 8'h00, 8'h00};
  // Clock fault flag is not judged on the partial first frame; only its power bit is checked.
  localparam logic [7:0] RM [14] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h02, 8'h03,
    8'hFF, 8'h0F, 8'hFF, 8'hFF};
  always #20 clk = ~clk;
  cccr_pcm_source src (.bit_clk(bclk), .frame_sync(fsync), .pcm_rx_line(rxd));
  cccr_top #(.SAMPLE_DIV(8), .FRAME_BITS(8'h1F)) dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fixed_io_select(fsel), .linear_mode(lin), .io_dir_out(dir), .io_in(io), .cs_in(4'h0),
    .io_reg_read(iord), .io_reg_read_chan(4'h0), .cs_reg_read(1'b0), .por_event(por), .bit_clk(bclk),
    .frame_sync(fsync), .pcm_rx_line(rxd), .rx_sample_valid(rx_valid), .rx_sample_ready(rdy),
    .rx_sample_data(rx_data), .tx_frame_start(tfs), .rx_frame_start(rfs), .digital_loop_sel(dls),
    .codec_side_loop_sel(cls), .tx_preamp_bits(tx_preamp_gain), .rx_amp_code(rx_amp_gain), .tx_loop_slot(slot), .irq(irq));
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    wt(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    wt(1);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    wt(1);
    reg_addr = a;
    reg_rd = 1'b1;
    wt(1);
    reg_rd = 1'b0;
    `CHK(n, e & m, reg_rdata & m)
  endtask
  task clr;
    iord = 1'b1;
    wt(1);
    iord = 1'b0;
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #(40 * 20000);
    bad_count++;
    end_of_test;
  end
  initial
  begin
    wt(20);
    reset_n = 1'b1;
    for (int i = 0; i < 14; i++)
      rd(8'h1A + 8'(i), RM[i], RV[i], "reset value");
    $display("test reset done");
    for (int i = 0; i < 9; i++)
    begin
      wr(WA[i], WD[i]);
      rd(WA[i], WM[i], WD[i], "readback");
    end
    `CHK("loop sel", 8'h5A, {dls, cls})
    `CHK("gain out", 16'hB56C, {tx_preamp_gain, rx_amp_gain})
    `CHK("slot copy", 8'h81, slot)
    wr(8'h21, 8'hFF);
    rd(8'h21, 8'hFF, 8'h00, "source ro");
    wr(8'h1B, 8'h00);
    $display("test registers done");
    // The first sample after a setting change may straddle it, so the second one is judged.
    for (int m = 0; m < 2; m++)
    begin
      repeat (2)
      begin
        nf = 0;
        wt(1);
        lin = m[0];
        for (int i = 0; i < 4000 && rx_valid !== 1'b1; i++)
        begin
          @(negedge clk);
          nf += rfs + tfs;
        end
      end
      `CHK("frame starts", 2, nf)
      `CHK("rx sample", m ? 16'hC1C2 : 16'h00C1, rx_data)
    end
    rd(8'h22, 8'h00, 8'h00, "fault flush");
    rd(8'h22, 8'h01, 8'h00, "clock count");
    por = 1'b1;
    wt(4);
    rd(8'h22, 8'h02, 8'h02, "power fault");
    por = 1'b0;
    rd(8'h22, 8'h02, 8'h02, "fault held");
    rd(8'h22, 8'h02, 8'h00, "fault clear");
    $display("test alarm done");
    fsel = 1'b1;
    wr(8'h1C, 8'hF7);
    io[3] = 1'b1;
    wt(40);
    `CHK("raw irq", 1'b1, irq)
    rd(8'h21, 8'h01, 8'h01, "static src");
    clr;
    rd(8'h21, 8'h01, 8'h00, "src clear");
    dir[3] = 1'b1;
    io[3:2] = 2'b01;
    wt(40);
    `CHK("masked irq", 1'b0, irq)
    wr(8'h1C, 8'hF6);
    io[0] = 1'b1;
    wt(12);
    io[0] = 1'b0;
    wt(80);
    `CHK("glitch irq", 1'b0, irq)
    io[0] = 1'b1;
    wt(80);
    `CHK("filter irq", 1'b1, irq)
    clr;
    wr(8'h1C, 8'hFD);
    io[1] = 1'b1;
    wt(24);
    `CHK("zero persist", 1'b1, irq)
    $display("test interrupts done");
    end_of_test;
  end
endmodule
